/* core/ctd_channel.sv */
// Chained transmit DMA channel: descriptor ring walker feeding a serial transmitter
`timescale 1ns/100ps
`include "ctd_consts.svh"

module ctd_channel
   import ctd_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   // Register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   // System memory read port
   output ctd_mem_req_t      mem_out,
   input  wire logic         mem_ack,
   input  wire logic [15:0]  mem_rdata,
   // Serial transmitter side
   input  wire logic         tx_req,
   output ctd_tx_t           tx_out,
   // Interrupt
   output logic              irq
);

   ctd_regs_t r;
   ctd_regs_t next_r;

   // Transfer unit size in bytes for the current count
   function automatic logic [15:0] step_of(input logic [15:0] cnt);
      step_of = (cnt >= 16'h0002) ? 16'h0002 : 16'h0001;
   endfunction : step_of

   // Register write select
   function automatic logic wr_hit(input logic [7:0] ofs, input logic [7:0] a, input logic w);
      wr_hit = w && (a == ofs);
   endfunction : wr_hit

   logic [15:0] step;
   logic [15:0] cnt_after;
   logic [1:0]  ev;
   logic        rd_stat;

   // Next-state logic
   always_comb begin
      next_r         = r;
      next_r.tx.valid = 1'b0;
      ev             = 2'b00;
      step           = step_of(r.byte_cnt);
      cnt_after      = r.byte_cnt - step;
      rd_stat        = reg_rd && (reg_addr == `CTD_OFS_INT_STAT);

      // Host register writes
      if (wr_hit(`CTD_OFS_CTRL, reg_addr, reg_wr)) begin
         next_r.enable = reg_wdata[`CTD_CTRL_EN_BIT];
         if (!r.enable) begin
            next_r.multi = reg_wdata[`CTD_CTRL_MULTI_BIT];
         end
      end
      if (wr_hit(`CTD_OFS_BASE, reg_addr, reg_wr) && !r.enable) begin
         next_r.base = reg_wdata[7:0];
      end
      if (wr_hit(`CTD_OFS_END_PTR, reg_addr, reg_wr)) begin
         next_r.end_ptr = reg_wdata[15:0];
      end
      if (wr_hit(`CTD_OFS_CUR_PTR, reg_addr, reg_wr) && !r.enable) begin
         next_r.cur_ptr = reg_wdata[15:0];
      end
      if (wr_hit(`CTD_OFS_INT_MASK, reg_addr, reg_wr)) begin
         next_r.int_mask = reg_wdata[1:0];
      end

      // Channel sequencer
      case (r.state)
         ST_IDLE: begin
            if (r.enable && tx_req) begin
               if (r.cur_ptr == r.end_ptr) begin
                  next_r.enable = 1'b0;
                  ev[`CTD_INT_MATCH_BIT] = 1'b1;
               end else begin
                  next_r.idx      = 2'h0;
                  next_r.mem.req  = 1'b1;
                  next_r.mem.word = 1'b1;
                  next_r.mem.addr = {r.base, r.cur_ptr};
                  next_r.state    = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (mem_ack) begin
               case (r.idx)
                  2'h0: next_r.d_chain = mem_rdata;
                  2'h1: next_r.d_bp[15:0] = mem_rdata;
                  2'h2: begin
                     next_r.d_bp[23:16] = mem_rdata[7:0];
                     next_r.d_st        = mem_rdata[15:8];
                  end
                  default: next_r.d_len = mem_rdata;
               endcase
               if (r.idx == `CTD_DESC_LAST_IDX) begin
                  next_r.mem.req = 1'b0;
                  next_r.state   = ST_LOAD;
               end else begin
                  next_r.idx      = r.idx + 2'h1;
                  // Stay inside the 64-kbyte descriptor region
                  next_r.mem.addr = {r.base, r.mem.addr[15:0] + 16'h0002};
               end
            end
         end
         ST_LOAD: begin
            next_r.buf_addr = r.d_bp;
            next_r.byte_cnt = r.d_len;
            if (r.d_len == 16'h0000) begin
               // Empty buffer: switch at once
               next_r.cur_ptr = r.d_chain;
               next_r.state   = ST_IDLE;
            end else begin
               next_r.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (r.enable && tx_req) begin
               next_r.mem.req  = 1'b1;
               next_r.mem.word = (step == 16'h0002);
               next_r.mem.addr = r.buf_addr;
               next_r.state    = ST_READ;
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               next_r.mem.req  = 1'b0;
               next_r.tx.valid = 1'b1;
               next_r.tx.word  = r.mem.word;
               next_r.tx.data  = r.mem.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
               next_r.tx.last  = 1'b0;
               next_r.buf_addr = r.buf_addr + {8'h00, step};
               next_r.byte_cnt = cnt_after;
               if (cnt_after == 16'h0000) begin
                  next_r.cur_ptr = r.d_chain;
                  next_r.tx.last = r.d_st[`CTD_ST_EOM_BIT];
                  next_r.state   = ST_IDLE;
                  if (r.d_st[`CTD_ST_EOM_BIT] || r.d_st[`CTD_ST_EOT_BIT]) begin
                     ev[`CTD_INT_FEND_BIT] = 1'b1;
                  end
                  if ((r.d_st[`CTD_ST_EOM_BIT] && !r.multi) || r.d_st[`CTD_ST_EOT_BIT]) begin
                     next_r.enable = 1'b0;
                  end
               end else begin
                  next_r.state = ST_WAIT;
               end
            end
         end
         default: begin
            next_r.state   = ST_IDLE;
            next_r.mem.req = 1'b0;
         end
      endcase

      // Sticky status: read clears, new event wins
      next_r.int_stat = (rd_stat ? 2'b00 : r.int_stat) | ev;

      // Read data, one cycle after the strobe
      next_r.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `CTD_OFS_CTRL:     next_r.rdata = {30'h0000_0000, r.multi, r.enable};
            `CTD_OFS_BASE:     next_r.rdata = {24'h00_0000, r.base};
            `CTD_OFS_END_PTR:  next_r.rdata = {16'h0000, r.end_ptr};
            `CTD_OFS_CUR_PTR:  next_r.rdata = {16'h0000, r.cur_ptr};
            `CTD_OFS_INT_STAT: next_r.rdata = {30'h0000_0000, r.int_stat};
            `CTD_OFS_INT_MASK: next_r.rdata = {30'h0000_0000, r.int_mask};
            `CTD_OFS_BYTE_CNT: next_r.rdata = {16'h0000, r.byte_cnt};
            `CTD_OFS_BUF_ADDR: next_r.rdata = {8'h00, r.buf_addr};
            default:           next_r.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r          <= '0;
         r.state    <= ST_IDLE;
         r.base     <= `CTD_RST_BASE;
         r.end_ptr  <= `CTD_RST_PTR;
         r.cur_ptr  <= `CTD_RST_PTR;
         r.int_mask <= `CTD_RST_MASK;
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign reg_rdata = r.rdata;
   assign mem_out   = r.mem;
   assign tx_out    = r.tx;
   assign irq       = |(r.int_stat & r.int_mask);

endmodule : ctd_channel

/* core/ctd_consts.svh */
// Offsets, field positions, reset values and counts of the chained transmit DMA channel
`ifndef CTD_CONSTS_SVH
`define CTD_CONSTS_SVH

// Register byte offsets
`define CTD_OFS_CTRL        8'h00
`define CTD_OFS_BASE        8'h04
`define CTD_OFS_END_PTR     8'h08
`define CTD_OFS_CUR_PTR     8'h0C
`define CTD_OFS_INT_STAT    8'h10
`define CTD_OFS_INT_MASK    8'h14
`define CTD_OFS_BYTE_CNT    8'h18
`define CTD_OFS_BUF_ADDR    8'h1C

// Control register fields
`define CTD_CTRL_EN_BIT     0
`define CTD_CTRL_MULTI_BIT  1

// Interrupt status and mask fields
`define CTD_INT_MATCH_BIT   0
`define CTD_INT_FEND_BIT    1

// Descriptor status field bits
`define CTD_ST_EOT_BIT      0
`define CTD_ST_EOM_BIT      7

// Descriptor layout: four 16-bit words
`define CTD_DESC_LAST_IDX   2'h3

// Reset values
`define CTD_RST_BASE        8'h00
`define CTD_RST_PTR         16'h0000
`define CTD_RST_MASK        2'h0

`endif

/* core/ctd_pkg.sv */
// Types of the chained transmit DMA channel
package ctd_pkg;

   // Channel sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b0_0001,
      ST_FETCH = 5'b0_0010,
      ST_LOAD  = 5'b0_0100,
      ST_WAIT  = 5'b0_1000,
      ST_READ  = 5'b1_0000
   } ctd_state_t;

   // Memory read request towards system memory
   typedef struct packed {
      logic        req;
      logic        word;
      logic [23:0] addr;
   } ctd_mem_req_t;

   // Data handed to the serial transmitter
   typedef struct packed {
      logic        valid;
      logic        word;
      logic        last;
      logic [15:0] data;
   } ctd_tx_t;

   // Whole channel state
   typedef struct packed {
      ctd_state_t   state;
      logic         enable;
      logic         multi;
      logic [7:0]   base;
      logic [15:0]  end_ptr;
      logic [15:0]  cur_ptr;
      logic [1:0]   int_stat;
      logic [1:0]   int_mask;
      logic [1:0]   idx;
      logic [15:0]  d_chain;
      logic [23:0]  d_bp;
      logic [7:0]   d_st;
      logic [15:0]  d_len;
      logic [23:0]  buf_addr;
      logic [15:0]  byte_cnt;
      logic [31:0]  rdata;
      ctd_mem_req_t mem;
      ctd_tx_t      tx;
   } ctd_regs_t;

endpackage : ctd_pkg

/* test/chained_tx_descriptor_dma_tb_top.sv */
// Register-level tests of the chained transmit DMA channel
`timescale 1ns/100ps
`include "ctd_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module chained_tx_descriptor_dma_tb_top
   import ctd_pkg::*;
;
   logic         clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0, mem_ack, irq;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wdata = 32'h0000_0000, reg_rdata, d;
   logic [15:0]  mem_rdata;
   logic [17:0]  units [$];
   ctd_mem_req_t mem_out;
   ctd_tx_t      tx_out;
   int           bad_count = 0, checks_done = 0;
   ctd_channel ctd_channel_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .tx_req(tx_req), .tx_out(tx_out), .irq(irq));
   ctd_mem_model ctd_mem_model_inst (.clk_sys(clk_sys), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial forever #25 clk_sys = ~clk_sys;
   // Units handed to the transmitter
   always @(posedge clk_sys)
      if (tx_out.valid)
         units.push_back({tx_out.word, tx_out.last, tx_out.data});
   function automatic logic [15:0] pat(input logic [23:0] a);
      return a[15:0] ^ 16'hA5C3;
   endfunction : pat
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
   endtask : wr
   // One read strobe; data taken mid-cycle after it drops, one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      `CHK($sformatf("reg %h", a), e, d)
   endtask : chk
   task automatic desc(input logic [15:0] p, n, input logic [23:0] bp, input logic [7:0] st, input logic [15:0] len);
      ctd_mem_model_inst.mem[{8'h12, p}] = n;
      ctd_mem_model_inst.mem[{8'h12, p + 16'h0002}] = bp[15:0];
      ctd_mem_model_inst.mem[{8'h12, p + 16'h0004}] = {st, bp[23:16]};
      ctd_mem_model_inst.mem[{8'h12, p + 16'h0006}] = len;
   endtask : desc
   // Poll the enable bit until the channel stops
   task automatic run;
      tx_req <= 1'b1;
      d = 32'h0000_0001;
      for (int i = 0; i < 400 && d[0] !== 1'b0; i++)
         rd(`CTD_OFS_CTRL);
      // Channel never stopped
      if (d[0] !== 1'b0)
         bad_count++;
      tx_req <= 1'b0;
   endtask : run
   task automatic print_verdict;
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      print_verdict();
   end
   // Single frame over two buffers, then a one-frame run in multi-frame mode ending on equal pointers
   initial begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk(8'hFC, 32'h0000_0000);
      desc(16'h0100, 16'h0108, 24'h34_0000, 8'h00, 16'h0003);
      desc(16'h0108, 16'h0110, 24'h34_0040, 8'h80, 16'h0002);
      desc(16'h0110, 16'h0118, 24'h34_0080, 8'h80, 16'h0002);
      wr(`CTD_OFS_BASE, 32'h0000_0012);
      wr(`CTD_OFS_CUR_PTR, 32'h0000_0100);
      wr(`CTD_OFS_INT_MASK, 32'h0000_0003);
      wr(`CTD_OFS_END_PTR, 32'h0000_0110);
      wr(`CTD_OFS_CTRL, 32'h0000_0001);
      wr(`CTD_OFS_BASE, 32'h0000_0077);
      chk(`CTD_OFS_END_PTR, 32'h0000_0110);
      run();
      chk(`CTD_OFS_CTRL, 32'h0000_0000);
      chk(`CTD_OFS_CUR_PTR, 32'h0000_0110);
      chk(`CTD_OFS_BASE, 32'h0000_0012);
      `CHK("units", 3, units.size())
      `CHK("unit0", {2'b10, pat(24'h34_0000)}, units[0])
      `CHK("unit1", {2'b00, 8'h02 ^ 8'hC3}, {units[1][17:16], units[1][7:0]})
      `CHK("unit2", {2'b11, pat(24'h34_0040)}, units[2])
      chk(`CTD_OFS_INT_STAT, 32'h0000_0002);
      units.delete();
      wr(`CTD_OFS_CTRL, 32'h0000_0003);
      wr(`CTD_OFS_END_PTR, 32'h0000_0118);
      chk(`CTD_OFS_END_PTR, 32'h0000_0118);
      run();
      chk(`CTD_OFS_CUR_PTR, 32'h0000_0118);
      `CHK("units", 1, units.size())
      `CHK("unit3", {2'b11, pat(24'h34_0080)}, units[0])
      `CHK("irq", 1'b1, irq)
      wr(`CTD_OFS_INT_MASK, 32'h0000_0000);
      chk(`CTD_OFS_INT_STAT, 32'h0000_0003);
      print_verdict();
   end
endmodule : chained_tx_descriptor_dma_tb_top

/* test/ctd_mem_model.sv */
// System memory model with mixed answer latency
`timescale 1ns/100ps
module ctd_mem_model
   import ctd_pkg::*;
(
   // Clock and read port
   input wire logic         clk_sys,
   input wire ctd_mem_req_t mem_out,
   output logic             mem_ack = 1'b0,
   output logic [15:0]      mem_rdata = 16'h0000
);
   logic [15:0] mem [int];
   int          wait_cnt = 0;
   logic        slow = 1'b0;
   // Prompt and slow answers in turn; idle data toggles
   always @(posedge clk_sys) begin
      if (mem_out.req && !mem_ack && wait_cnt >= (slow ? 2 : 0)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem.exists(mem_out.addr) ? mem[mem_out.addr] : mem_out.addr[15:0] ^ 16'hA5C3;
         slow      <= ~slow;
         wait_cnt  <= 0;
      end else begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_cnt  <= mem_out.req ? wait_cnt + 1 : 0;
      end
   end
endmodule : ctd_mem_model

/* test/ctd_monitor.sv */
// Port checker of the chained transmit DMA channel
`timescale 1ns/100ps
`include "ctd_consts.svh"
module ctd_monitor
   import ctd_pkg::*;
(
   // Clock, reset, register port
   input wire logic         clk_sys,
   input wire logic         resetn,
   input wire logic [7:0]   reg_addr,
   input wire logic [31:0]  reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   // Memory, transmitter, interrupt
   input wire ctd_mem_req_t mem_out,
   input wire logic         mem_ack,
   input wire ctd_tx_t      tx_out,
   input wire logic         irq
);
   logic [1:0] mask;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Shadow of the interrupt mask
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         mask <= 2'h0;
      else if (reg_wr && reg_addr == `CTD_OFS_INT_MASK)
         mask <= reg_wdata[1:0];
   end
   // Port timing
   rdata_quiet_a : assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("stray read data");
   end_readback_a :
      assert property (reg_wr && reg_addr == `CTD_OFS_END_PTR ##1 reg_rd && reg_addr == `CTD_OFS_END_PTR
         |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 2)}) else $error("end pointer lost");
   req_hold_a :
      assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr)) else $error("request moved");
   req_step_a :
      assert property (mem_out.req && mem_ack |=> !mem_out.req || mem_out.addr == $past(mem_out.addr) + 24'h00_0002)
         else $error("bad fetch step");
   tx_pulse_a : assert property (tx_out.valid |=> !tx_out.valid) else $error("long valid");
   tx_cause_a :
      assert property (tx_out.valid |-> $past(mem_ack)) else $error("unit without read");
   irq_masked_a :
      assert property (mask == 2'h0 |-> !irq) else $error("masked interrupt");
   irq_frame_a :
      assert property (tx_out.valid && tx_out.last && mask[1] |-> ##[0:3] irq) else $error("no frame interrupt");
endmodule : ctd_monitor

bind ctd_channel ctd_monitor ctd_monitor_inst (
   .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_ack(mem_ack), .tx_out(tx_out), .irq(irq)
);
